// [rtl/srx_pkg.sv]
// package: register map, field positions and shared types of the serial receiver
package srx_pkg;
  // register byte offsets on the apb bus
  localparam logic [7:0] SRX_OFF_RSC = 8'h00;  // receive_status_control
  localparam logic [7:0] SRX_OFF_RDATA = 8'h04;  // receive_data
  localparam logic [7:0] SRX_OFF_TSC = 8'h08;  // transmit_status_control
  localparam logic [7:0] SRX_OFF_BAUD = 8'h0C;  // baud_control (bit period)
  localparam logic [7:0] SRX_OFF_IRQ_STAT = 8'h10;  // sticky event status
  localparam logic [7:0] SRX_OFF_IRQ_MASK = 8'h14;  // event mask
  // receive_status_control bit positions
  localparam int SRX_B_SERIAL_PORT_ENABLE = 7;  // serial_port_enable
  localparam int SRX_B_RX9 = 6;  // nine_bit_receive_enable
  localparam int SRX_B_SINGLE_RECEIVE_ENABLE = 5;  // single_receive_enable
  localparam int SRX_B_CONTINUOUS_RECEIVE_ENABLE = 4;  // continuous_receive_enable
  localparam int SRX_B_ADDRESS_DETECT_ENABLE = 3;  // address_detect_enable
  localparam int SRX_B_FRAMING_ERROR_FLAG = 2;  // framing_error_flag
  localparam int SRX_B_OVERRUN_ERROR_FLAG = 1;  // overrun_error_flag
  localparam int SRX_B_NINTH_DATA_BIT = 0;  // ninth_data_bit
  // transmit_status_control bit positions
  localparam int SRX_B_CLOCK_SOURCE_MASTER_SELECT = 7;  // clock_source_master_select
  localparam int SRX_B_SYNC = 4;  // clocked_mode_select
  // interrupt status bit positions
  localparam int SRX_I_RCIF = 0;  // receive_interrupt_flag (character available)
  localparam int SRX_I_WAKE = 1;  // character stored while asleep in sync slave mode
  localparam int SRX_IRQ_W = 2;  // event count
  // reset value, fifo depth and data bit counts
  localparam logic [7:0] SRX_BAUD_RST = 8'h0F;  // bit period minus one, pclk cycles
  localparam int SRX_FIFO_DEPTH = 2;  // receive fifo holds two characters
  localparam logic [3:0] SRX_BITS8 = 4'h8;  // data bits, normal mode
  localparam logic [3:0] SRX_BITS9 = 4'h9;  // data bits, nine-bit mode
  // one fifo entry: data, ninth bit and its own framing status
  typedef struct packed {
    logic framing_error_flag;
    logic bit9;
    logic [7:0] data;
  } srx_char_t;
endpackage : srx_pkg

// [rtl/srx_receiver.sv]
// module: serial receive path with fifo, error flags, address detect, apb registers
//
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/1ns
module srx_receiver
  import srx_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_data_pin,  // serial_data_pin input
  input wire logic rx_clock_pin,  // serial_clock_pin input (sync slave)
  input wire logic core_sleep,  // core asleep, from the power controller
  output logic irq,  // level interrupt
  output logic wake_q  // wake request to the core
);
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0] rsc_q;  // control bits of receive_status_control
  logic [7:0] tsc_q;  // transmit_status_control
  logic [7:0] baud_q;  // bit period minus one
  logic [SRX_IRQ_W-1:0] ista_q;  // sticky events
  logic [SRX_IRQ_W-1:0] imask_q;  // event mask
  logic overrun_error_flag_q;  // overrun_error_flag
  srx_char_t fifo_q [SRX_FIFO_DEPTH];  // receive fifo storage
  logic rd_ptr_q;  // oldest entry
  logic wr_ptr_q;  // next free entry
  logic [1:0] count_q;  // entries held
  logic prdy_q;  // apb answer strobe
  logic [31:0] prdata_q;  // apb read data
  logic wake_d;
  // decode helpers
  logic serial_port_enable, continuous_receive_enable, rx9, address_detect_enable, sync_mode, slave_mode, rx_on;
  logic setup, acc_w, acc_r, rd_data;
  srx_char_t head;
  assign serial_port_enable = rsc_q[SRX_B_SERIAL_PORT_ENABLE];
  assign continuous_receive_enable = rsc_q[SRX_B_CONTINUOUS_RECEIVE_ENABLE];
  assign rx9 = rsc_q[SRX_B_RX9];
  assign address_detect_enable = rsc_q[SRX_B_ADDRESS_DETECT_ENABLE];
  assign sync_mode = tsc_q[SRX_B_SYNC];
  assign slave_mode = sync_mode && !tsc_q[SRX_B_CLOCK_SOURCE_MASTER_SELECT];
  // sync slave ignores single_receive_enable; only continuous_receive_enable enables reception
  assign rx_on = serial_port_enable && (continuous_receive_enable || (!slave_mode && rsc_q[SRX_B_SINGLE_RECEIVE_ENABLE]));
  assign head = fifo_q[rd_ptr_q];
  // apb access phases: answer one cycle after setup
  assign setup = psel && !penable;
  assign acc_w = psel && penable && pready && pwrite;
  assign acc_r = psel && penable && pready && !pwrite;
  assign rd_data = acc_r && (paddr == SRX_OFF_RDATA) && (count_q != 2'h0);
  assign pready = prdy_q;
  assign prdata = prdata_q;
  assign pslverr = 1'b0;

  // function: decode of a mapped address, used by the read mux only (pslverr is tied low)
  function automatic logic srx_mapped(input logic [7:0] a);
    srx_mapped = (a == SRX_OFF_RSC) || (a == SRX_OFF_RDATA) || (a == SRX_OFF_TSC) ||
                 (a == SRX_OFF_BAUD) || (a == SRX_OFF_IRQ_STAT) || (a == SRX_OFF_IRQ_MASK);
  endfunction : srx_mapped

  // ---------------------------------------------------------------
  // pin synchronisers: three flops, change when 2nd and 3rd agree
  // ---------------------------------------------------------------
  logic [2:0] dsy_q, csy_q;
  logic din_q, cin_q;  // filtered levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dsy_q <= 3'h7;
      // link clock parks high: reset to that level so no false edge follows
      csy_q <= 3'h7;
      din_q <= 1'b1;
      cin_q <= 1'b1;
    end else begin
      dsy_q <= {dsy_q[1:0], rx_data_pin};
      csy_q <= {csy_q[1:0], rx_clock_pin};
      if (dsy_q[1] == dsy_q[2]) begin
        din_q <= dsy_q[2];
      end
      if (csy_q[1] == csy_q[2]) begin
        cin_q <= csy_q[2];
      end
    end
  end
  logic cin_prev_q;  // for edge detect of the filtered clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cin_prev_q <= 1'b1;
    end else begin
      cin_prev_q <= cin_q;
    end
  end
  logic sclk_fall;  // slave samples data on falling clock edge
  assign sclk_fall = cin_prev_q && !cin_q;

  // ---------------------------------------------------------------
  // receive shift engine
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {SRX_IDLE, SRX_START, SRX_DATA, SRX_STOP} srx_state_t;
  srx_state_t st_q;
  logic [7:0] tick_q;  // bit period counter
  logic [3:0] nbit_q;  // data bits taken
  logic [8:0] rsr_q;  // receive_shift_register
  logic done_q;  // one-cycle pulse: character complete
  logic fe_q;  // framing status of completed character
  logic [3:0] nbits;
  assign nbits = rx9 ? SRX_BITS9 : SRX_BITS8;
  logic [8:0] rsr_in;  // lsb-first shift, aligned by width
  assign rsr_in = rx9 ? {din_q, rsr_q[8:1]} : {1'b0, din_q, rsr_q[7:1]};

  // state machine: async start/data/stop, sync counts clock edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= SRX_IDLE;
      tick_q <= 8'h00;
      nbit_q <= 4'h0;
      rsr_q <= 9'h000;
      done_q <= 1'b0;
      fe_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (!rx_on || overrun_error_flag_q) begin
        // disabled or overrun: no new characters
        st_q <= SRX_IDLE;
        nbit_q <= 4'h0;
      end else if (sync_mode) begin
        // clocked mode: take one bit per falling clock edge, no start or stop
        if (sclk_fall) begin
          rsr_q <= rsr_in;
          if (nbit_q == nbits - 4'h1) begin
            nbit_q <= 4'h0;
            done_q <= 1'b1;
            fe_q <= 1'b0;
          end else begin
            nbit_q <= nbit_q + 4'h1;
          end
        end
      end else begin
        unique case (st_q)
          SRX_IDLE: begin
            if (!din_q) begin
              st_q <= SRX_START;
              tick_q <= {1'b0, baud_q[7:1]};  // half a bit to centre
            end
          end
          SRX_START: begin
            if (tick_q != 8'h00) begin
              tick_q <= tick_q - 8'h01;
            end else if (din_q) begin
              st_q <= SRX_IDLE;  // glitch, not a start bit
            end else begin
              st_q <= SRX_DATA;
              tick_q <= baud_q;
              nbit_q <= 4'h0;
            end
          end
          SRX_DATA: begin
            if (tick_q != 8'h00) begin
              tick_q <= tick_q - 8'h01;
            end else begin
              rsr_q <= rsr_in;
              tick_q <= baud_q;
              if (nbit_q == nbits - 4'h1) begin
                st_q <= SRX_STOP;
              end else begin
                nbit_q <= nbit_q + 4'h1;
              end
            end
          end
          SRX_STOP: begin
            if (tick_q != 8'h00) begin
              tick_q <= tick_q - 8'h01;
            end else begin
              // stop bit missing at its slot: framing error, keep going
              fe_q <= !din_q;
              done_q <= 1'b1;
              st_q <= SRX_IDLE;
            end
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // receive fifo and overrun
  // ---------------------------------------------------------------
  logic accept;  // nine-bit address mode drops ninth-bit-clear characters
  assign accept = done_q && !(address_detect_enable && rx9 && !rsr_q[8]);
  logic push;
  assign push = accept && (count_q != 2'(SRX_FIFO_DEPTH));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_ptr_q <= 1'b0;
      wr_ptr_q <= 1'b0;
      count_q <= 2'h0;
      for (int i = 0; i < SRX_FIFO_DEPTH; i++) begin
        fifo_q[i] <= '0;
      end
    end else if (!serial_port_enable) begin
      // port reset empties fifo, so framing_error_flag reads clear
      rd_ptr_q <= 1'b0;
      wr_ptr_q <= 1'b0;
      count_q <= 2'h0;
    end else begin
      if (push) begin
        // framing status stored with its character
        fifo_q[wr_ptr_q] <= '{framing_error_flag: fe_q, bit9: rsr_q[8], data: rsr_q[7:0]};
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (rd_data) begin
        rd_ptr_q <= ~rd_ptr_q;  // data read advances fifo
      end
      count_q <= count_q + 2'(push) - 2'(rd_data);
    end
  end
  // overrun: third whole character with fifo full only continuous_receive_enable/serial_port_enable clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overrun_error_flag_q <= 1'b0;
    end else if (!serial_port_enable || !continuous_receive_enable) begin
      overrun_error_flag_q <= 1'b0;
    end else if (accept && count_q == 2'(SRX_FIFO_DEPTH)) begin
      overrun_error_flag_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // interrupts: sticky status, write one to clear, set wins
  // ---------------------------------------------------------------
  logic [SRX_IRQ_W-1:0] iev;
  // only a stored character is an event; framing error alone is not
  assign iev[SRX_I_RCIF] = push;
  assign iev[SRX_I_WAKE] = push && core_sleep && slave_mode;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ista_q <= '0;
    end else begin
      ista_q <= (ista_q & ~((acc_w && paddr == SRX_OFF_IRQ_STAT) ?
                pwdata[SRX_IRQ_W-1:0] : '0)) | iev;
    end
  end
  // irq flop and wake: unmasked receive flag wakes a sleeping core
  logic irq_q;
  assign irq = irq_q;
  assign wake_d = core_sleep && (|(ista_q & imask_q));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      irq_q <= |(ista_q & imask_q);
      wake_q <= wake_d;
    end
  end

  // ---------------------------------------------------------------
  // apb register writes
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsc_q <= 8'h00;
      tsc_q <= 8'h00;
      baud_q <= SRX_BAUD_RST;
      imask_q <= '0;
    end else if (acc_w) begin
      unique case (paddr)
        SRX_OFF_RSC: rsc_q <= pwdata[7:0] & 8'hF8;  // status bits read-only
        SRX_OFF_TSC: tsc_q <= pwdata[7:0];
        SRX_OFF_BAUD: baud_q <= pwdata[7:0];
        SRX_OFF_IRQ_MASK: imask_q <= pwdata[SRX_IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // apb answer and read data (one wait-free access cycle)
  // ---------------------------------------------------------------
  logic [7:0] rsc_view;  // framing_error_flag/ninth_data_bit of oldest char, zero when empty
  assign rsc_view = {rsc_q[7:3],
                     (count_q != 2'h0) && head.framing_error_flag, overrun_error_flag_q,
                     (count_q != 2'h0) && head.bit9};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdy_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      prdy_q <= setup;
      if (setup && !pwrite) begin
        unique case (paddr)
          SRX_OFF_RSC: prdata_q <= {24'h000000, rsc_view};
          SRX_OFF_RDATA: prdata_q <= {24'h000000, head.data};
          SRX_OFF_TSC: prdata_q <= {24'h000000, tsc_q};
          SRX_OFF_BAUD: prdata_q <= {24'h000000, baud_q};
          SRX_OFF_IRQ_STAT: prdata_q <= {30'h0, ista_q};
          SRX_OFF_IRQ_MASK: prdata_q <= {30'h0, imask_q};
          default: prdata_q <= srx_mapped(paddr) ? prdata_q : 32'h0000_0000;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_ovr_sets: assert property (@(posedge pclk) disable iff (!presetn)
    (accept && count_q == 2'h2 && serial_port_enable && continuous_receive_enable) |=> overrun_error_flag_q)
    else $error("overrun not flagged on third character");
  a_ovr_blocks: assert property (@(posedge pclk) disable iff (!presetn)
    overrun_error_flag_q |-> !push) else $error("character stored during overrun");
  a_ovr_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (overrun_error_flag_q && !$past(overrun_error_flag_q)) |-> $past(serial_port_enable && continuous_receive_enable))
    else $error("overrun rose while disabled");
  a_serial_port_enable_flush: assert property (@(posedge pclk) disable iff (!presetn)
    !serial_port_enable |=> (count_q == 2'h0 && !rsc_view[SRX_B_FRAMING_ERROR_FLAG]))
    else $error("port disable left framing_error_flag or data");
  a_addr_drop: assert property (@(posedge pclk) disable iff (!presetn)
    (done_q && address_detect_enable && rx9 && !rsr_q[8]) |=> $stable(count_q) || $past(rd_data))
    else $error("address mode stored data character");
  a_read_adv: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_data && !push && serial_port_enable) |=> count_q == $past(count_q) - 2'h1)
    else $error("data read did not advance fifo");
  a_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
    push |=> ista_q[SRX_I_RCIF]) else $error("receive flag not set");
  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    (ista_q == '0) |=> !irq_q) else $error("interrupt without a character");
  a_fe_stored: assert property (@(posedge pclk) disable iff (!presetn)
    push |=> fifo_q[$past(wr_ptr_q)].framing_error_flag == $past(fe_q))
    else $error("framing status not stored");
endmodule : srx_receiver

// [tb/srx_remote_tx.sv]
// remote transmitter model: drives async frames and sync slave clock plus data
`timescale 1ns/1ns
module srx_remote_tx
  import srx_pkg::*;
(
  input wire logic pclk,
  output logic data_pin,
  output logic clock_pin
);
  // -----------------------------------------------------------------
  // line state
  // -----------------------------------------------------------------
  localparam int BIT_CYC = int'(SRX_BAUD_RST) + 1;  // bit time in pclk cycles

  // idle: data pulled high, link clock parked high
  initial begin
    data_pin = 1'b1;
    clock_pin = 1'b1;
  end

  // async frame: start low, data lsb first, stop high unless a bad stop is wanted
  task automatic send_async(input logic [8:0] v, input int nb, input logic stop_ok);
    data_pin <= 1'b0;
    repeat (BIT_CYC) @(posedge pclk);
    for (int i = 0; i < nb; i++) begin
      data_pin <= v[i];
      repeat (BIT_CYC) @(posedge pclk);
    end
    data_pin <= stop_ok;
    repeat (BIT_CYC) @(posedge pclk);
    data_pin <= 1'b1;
    repeat (2 * BIT_CYC) @(posedge pclk);
  endtask : send_async

  // sync frame: 320 ns link clock, data held across each falling edge
  task automatic send_sync(input logic [8:0] v, input int nb);
    #13;
    for (int i = 0; i < nb; i++) begin
      data_pin = v[i];
      #147 clock_pin = 1'b0;
      #160 clock_pin = 1'b1;
      #13;
    end
    // released line shows the inverse of the last bit
    data_pin = ~data_pin;
    repeat (8) @(posedge pclk);
  endtask : send_sync
endmodule : srx_remote_tx

// [tb/test_serial_receive_error_addr_detect.sv]
// testbench: register-level checks of the serial receiver with a remote transmitter
`timescale 1ns/1ns
module test_serial_receive_error_addr_detect
  import srx_pkg::*;
;
  // -----------------------------------------------------------------
  // signals
  // -----------------------------------------------------------------
  typedef struct packed {logic [7:0] a; logic [31:0] v;} srx_note_t;  // expected read
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic rx_data_pin, rx_clock_pin, core_sleep, irq, wake_q;
  srx_note_t notes[$];  // pending read expectations
  srx_note_t note;
  int fail_count = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [31:0] seed = 32'h0000_002B;  // xorshift state
  logic [7:0] a, b;
  logic [7:0] d[4];

  srx_receiver i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_data_pin(rx_data_pin), .rx_clock_pin(rx_clock_pin),
    .core_sleep(core_sleep), .irq(irq), .wake_q(wake_q));
  srx_remote_tx i_far (.pclk(pclk), .data_pin(rx_data_pin), .clock_pin(rx_clock_pin));

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : xs

  task automatic results();
    if (fail_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results

  // one apb transfer: setup, access held until pready, then release
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] dt);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= dt;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // wait for the answer; only the bench timeout ends a hung access
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
    apb(1'b1, ad, dt);
  endtask : wr

  task automatic rd(input logic [7:0] ad, input logic [31:0] v);
    notes.push_back({ad, v});
    apb(1'b0, ad, 32'h0000_0000);
  endtask : rd

  // status first, then data, as software must
  task automatic getc(input logic [7:0] ctl, input logic [8:0] v, input logic fe);
    rd(SRX_OFF_RSC, {24'h000000, ctl | {5'h00, fe, 1'b0, v[8]}});
    rd(SRX_OFF_RDATA, {24'h000000, v[7:0]});
  endtask : getc

  task automatic chk(input string nm, input logic e, input logic s);
    tests_run++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected %s expected %b seen %b", nm, e, s);
    end
  endtask : chk

  // -----------------------------------------------------------------
  // clock, timeout and read monitor
  // -----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fail_count++;
      results();
    end
  end

  // compare each completed read with the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && pwrite === 1'b0 && notes.size() > 0) begin
      note = notes.pop_front();
      tests_run++;
      if (prdata !== note.v) begin
        fail_count++;
        $display("unexpected reg %h expected %h seen %h", note.a, note.v, prdata);
      end
    end
  end

  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    core_sleep = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(SRX_OFF_BAUD, {24'h000000, SRX_BAUD_RST});
    rd(8'h18, 32'h0000_0000);
    chk("pslverr", 1'b0, pslverr);
    // good then bad stop, interrupt masked then unmasked
    wr(SRX_OFF_IRQ_MASK, 32'h0000_0000);
    wr(SRX_OFF_RSC, 32'h0000_0090);
    a = xs();
    b = xs();
    i_far.send_async({1'b0, a}, 8, 1'b1);
    i_far.send_async({1'b0, b}, 8, 1'b0);
    chk("irq", 1'b0, irq);
    wr(SRX_OFF_IRQ_MASK, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    chk("irq", 1'b1, irq);
    getc(8'h90, {1'b0, a}, 1'b0);
    getc(8'h90, {1'b0, b}, 1'b1);
    wr(SRX_OFF_IRQ_STAT, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    chk("irq", 1'b0, irq);
    // framing status survives receive disable, not port disable
    i_far.send_async({1'b0, a}, 8, 1'b0);
    rd(SRX_OFF_RSC, 32'h0000_0094);
    wr(SRX_OFF_RSC, 32'h0000_0080);
    rd(SRX_OFF_RSC, 32'h0000_0084);
    wr(SRX_OFF_RSC, 32'h0000_0000);
    rd(SRX_OFF_RSC, 32'h0000_0000);
    // overrun: four characters into a two-deep fifo
    wr(SRX_OFF_RSC, 32'h0000_0090);
    for (int i = 0; i < 4; i++) begin
      d[i] = xs();
      i_far.send_async({1'b0, d[i]}, 8, 1'b1);
    end
    rd(SRX_OFF_RSC, 32'h0000_0092);
    rd(SRX_OFF_RDATA, {24'h000000, d[0]});
    rd(SRX_OFF_RSC, 32'h0000_0092);
    rd(SRX_OFF_RDATA, {24'h000000, d[1]});
    wr(SRX_OFF_RSC, 32'h0000_0080);
    rd(SRX_OFF_RSC, 32'h0000_0080);
    // nine-bit reception
    wr(SRX_OFF_RSC, 32'h0000_00D0);
    a = xs();
    i_far.send_async({1'b1, a}, 9, 1'b1);
    getc(8'hD0, {1'b1, a}, 1'b0);
    // address detect: plain character dropped, address kept
    wr(SRX_OFF_RSC, 32'h0000_00D8);
    a = xs();
    b = xs();
    i_far.send_async({1'b0, a}, 9, 1'b1);
    i_far.send_async({1'b1, b}, 9, 1'b1);
    getc(8'hD8, {1'b1, b}, 1'b0);
    wr(SRX_OFF_RSC, 32'h0000_00D0);
    i_far.send_async({1'b0, a}, 9, 1'b1);
    getc(8'hD0, {1'b0, a}, 1'b0);
    wr(SRX_OFF_RSC, 32'h0000_00D8);
    // sync slave: single-receive alone does nothing
    wr(SRX_OFF_RSC, 32'h0000_0000);
    wr(SRX_OFF_IRQ_STAT, 32'h0000_0003);
    wr(SRX_OFF_TSC, 32'h0000_0010);
    wr(SRX_OFF_RSC, 32'h0000_00A0);
    i_far.send_sync({1'b0, xs()}, 8);
    rd(SRX_OFF_IRQ_STAT, 32'h0000_0000);
    // character completed while asleep wakes the core
    wr(SRX_OFF_RSC, 32'h0000_00B0);
    wr(SRX_OFF_IRQ_MASK, 32'h0000_0003);
    core_sleep <= 1'b1;
    b = xs();
    i_far.send_sync({1'b0, b}, 8);
    chk("wake_q", 1'b1, wake_q);
    chk("irq", 1'b1, irq);
    core_sleep <= 1'b0;
    getc(8'hB0, {1'b0, b}, 1'b0);
    wr(SRX_OFF_IRQ_STAT, 32'h0000_0003);
    repeat (2) @(posedge pclk);
    chk("irq", 1'b0, irq);
    repeat (4) @(posedge pclk);
    results();
  end
endmodule : test_serial_receive_error_addr_detect
